// File: include/rdcfg_pkg.sv
// constants, types and reset values for the re-driver configuration block
package rdcfg_pkg;

    // ****************************************
    // geometry
    // ****************************************
    localparam int NCH    = 8;
    localparam int NGRP   = 2;
    localparam int LANES  = 4;
    localparam int GRP_A  = 0;
    localparam int GRP_B  = 1;
    localparam int EQ_W   = 3;
    localparam int SW_W   = 2;
    localparam int DE_W   = 3;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS     = 10;
    localparam int DET_TO_NS  = 10000;
    localparam int DET_CYC    = (DET_TO_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W      = 10;
    localparam logic [TMR_W-1:0] TMR_END = TMR_W'(DET_CYC - 1);
    localparam logic [1:0]       CAP_WAIT = 2'h2;

    // ****************************************
    // register byte indices and fields
    // ****************************************
    localparam logic [3:0] IDX_LBEC  = 4'h2;
    localparam logic [3:0] IDX_RESET = 4'h5;
    localparam logic [3:0] IDX_PWR   = 4'h6;
    localparam logic [3:0] IDX_RXDE  = 4'h7;
    localparam logic [3:0] IDX_AEOC  = 4'h8;
    localparam logic [3:0] IDX_BEOC  = 4'h9;
    localparam int LB_BIT   = 0;
    localparam int EMA_BIT  = 1;
    localparam int EMB_BIT  = 2;
    localparam int RST_BIT  = 0;
    localparam int PD_BIT   = 0;
    localparam int RXA_BIT  = 0;
    localparam int RXB_BIT  = 1;
    localparam int EQ_LSB   = 0;
    localparam int SW_LSB   = 3;
    localparam int DE_LSB   = 5;

    // ****************************************
    // termination encodings
    // ****************************************
    localparam logic [1:0] IN_HIZ   = 2'h0;
    localparam logic [1:0] IN_PD50  = 2'h1;
    localparam logic [1:0] OUT_HIZ  = 2'h0;
    localparam logic [1:0] OUT_PU2K = 2'h1;
    localparam logic [1:0] OUT_PU50 = 2'h2;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        DET_IDLE = 2'h0,
        DET_WAIT = 2'h1,
        DET_DONE = 2'h3
    } rdcfg_det_t;

    typedef struct packed {
        logic                      lb_n;
        logic                      rst_n;
        logic                      pd_n;
        logic [NGRP-1:0]           rxd;
        logic [NGRP-1:0]           emph;
        logic [NGRP-1:0][EQ_W-1:0] eq;
        logic [NGRP-1:0][SW_W-1:0] sw;
        logic [NGRP-1:0][DE_W-1:0] de;
    } rdcfg_cfg_t;

    typedef struct packed {
        logic       mode;
        rdcfg_cfg_t cfg;
    } rdcfg_pins_t;

    typedef struct packed {
        rdcfg_pins_t              pin_s1;
        rdcfg_pins_t              pin_s2;
        logic [NCH-1:0]           sig_s1;
        logic [NCH-1:0]           sig_s2;
        logic [NCH-1:0]           load_s1;
        logic [NCH-1:0]           load_s2;
        logic [1:0]               cap_cnt;
        logic                     cap_done;
        rdcfg_cfg_t               regs;
        rdcfg_cfg_t               eff;
        logic                     refused;
        logic                     rst_prev;
        rdcfg_det_t               st;
        logic [TMR_W-1:0]         tmr;
        logic [NCH-1:0]           found;
        logic [NCH-1:0][1:0]      in_term;
        logic [NCH-1:0][1:0]      out_term;
    } rdcfg_st_t;

    // de-emphasis and detection enabled until straps are seen
    localparam rdcfg_cfg_t CFG_RST = '{
        lb_n: 1'h1, rst_n: 1'h0, pd_n: 1'h1, rxd: 2'h3, emph: 2'h3,
        eq: 6'h00, sw: 4'h0, de: 6'h00};

endpackage : rdcfg_pkg

// File: hw/rdcfg_core.sv
// strap/register configuration, receiver detection and lane control
`timescale 1ns/100ps
module rdcfg_core
    import rdcfg_pkg::*;
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    // strap pins
    input  wire logic                      cfg_from_pins,
    input  wire logic                      loopback_n,
    input  wire logic                      chan_reset_n,
    input  wire logic                      power_down_n,
    input  wire logic                      rx_detect_en_a,
    input  wire logic                      rx_detect_en_b,
    input  wire logic                      emphasis_type_grp_a,
    input  wire logic                      emphasis_type_grp_b,
    input  wire logic [EQ_W-1:0]           equalizer_select_a,
    input  wire logic [EQ_W-1:0]           equalizer_select_b,
    input  wire logic [SW_W-1:0]           swing_select_a,
    input  wire logic [SW_W-1:0]           swing_select_b,
    input  wire logic [DE_W-1:0]           deemph_level_select_a,
    input  wire logic [DE_W-1:0]           deemph_level_select_b,
    // register writes from the serial control slave
    input  wire logic                      reg_wr,
    input  wire logic [3:0]                reg_wr_idx,
    input  wire logic [7:0]                reg_wr_data,
    output logic                           reg_wr_refused,
    // analog comparators per channel
    input  wire logic [NCH-1:0]            input_level_valid,
    input  wire logic [NCH-1:0]            load_sense,
    // status
    output logic [NCH-1:0]                 sig_present,
    output logic [NCH-1:0]                 load_found,
    output logic                           load_found_grp_a,
    output logic                           load_found_grp_b,
    output logic                           detect_busy,
    // lane control
    output logic [NCH-1:0][1:0]            in_term,
    output logic [NCH-1:0][1:0]            out_term,
    output logic                           loopback_n_out,
    output logic [NGRP-1:0]                emph_deemph,
    output logic [NGRP-1:0][EQ_W-1:0]      eq_code,
    output logic [NGRP-1:0][SW_W-1:0]      swing_code,
    output logic [NGRP-1:0][DE_W-1:0]      deemph_code
);

    // ****************************************
    // state
    // ****************************************
    rdcfg_st_t         q;
    rdcfg_st_t         d;
    int unsigned       g;
    logic [NCH-1:0]    drv_w;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        d = q;
        g = 0;
        // every pin passes two flops before use
        d.pin_s1.mode          = cfg_from_pins;
        d.pin_s1.cfg.lb_n      = loopback_n;
        d.pin_s1.cfg.rst_n     = chan_reset_n;
        d.pin_s1.cfg.pd_n      = power_down_n;
        d.pin_s1.cfg.rxd       = {rx_detect_en_b, rx_detect_en_a};
        d.pin_s1.cfg.emph      = {emphasis_type_grp_b, emphasis_type_grp_a};
        d.pin_s1.cfg.eq        = {equalizer_select_b, equalizer_select_a};
        d.pin_s1.cfg.sw        = {swing_select_b, swing_select_a};
        d.pin_s1.cfg.de        = {deemph_level_select_b, deemph_level_select_a};
        d.pin_s2               = q.pin_s1;
        d.sig_s1               = input_level_valid;
        d.sig_s2               = q.sig_s1;
        d.load_s1              = load_sense;
        d.load_s2              = q.load_s1;
        d.refused              = 1'b0;

        // one-time capture once the synchronisers hold real pin levels
        if (!q.cap_done)
        begin
            if (q.cap_cnt == CAP_WAIT)
            begin
                d.regs     = q.pin_s2.cfg;
                d.cap_done = 1'b1;
            end
            else
            begin
                d.cap_cnt = q.cap_cnt + 2'h1;
            end
            d.refused = reg_wr;
        end
        else if (reg_wr && q.pin_s2.mode)
        begin
            d.refused = 1'b1;
        end
        else if (reg_wr)
        begin
            case (reg_wr_idx)
                IDX_LBEC:
                begin
                    d.regs.lb_n        = reg_wr_data[LB_BIT];
                    d.regs.emph[GRP_A] = reg_wr_data[EMA_BIT];
                    d.regs.emph[GRP_B] = reg_wr_data[EMB_BIT];
                end
                IDX_RESET: d.regs.rst_n = reg_wr_data[RST_BIT];
                IDX_PWR:   d.regs.pd_n  = reg_wr_data[PD_BIT];
                IDX_RXDE:
                begin
                    d.regs.rxd[GRP_A] = reg_wr_data[RXA_BIT];
                    d.regs.rxd[GRP_B] = reg_wr_data[RXB_BIT];
                end
                IDX_AEOC:
                begin
                    d.regs.eq[GRP_A] = reg_wr_data[EQ_LSB +: EQ_W];
                    d.regs.sw[GRP_A] = reg_wr_data[SW_LSB +: SW_W];
                    d.regs.de[GRP_A] = reg_wr_data[DE_LSB +: DE_W];
                end
                IDX_BEOC:
                begin
                    d.regs.eq[GRP_B] = reg_wr_data[EQ_LSB +: EQ_W];
                    d.regs.sw[GRP_B] = reg_wr_data[SW_LSB +: SW_W];
                    d.regs.de[GRP_B] = reg_wr_data[DE_LSB +: DE_W];
                end
                default:
                begin
                    d.regs = q.regs;
                end
            endcase
        end

        // mode is read live each cycle, so pin mode follows the straps
        d.eff      = q.pin_s2.mode ? q.pin_s2.cfg : q.regs;
        d.rst_prev = q.eff.rst_n;

        // receiver detection
        if (!q.eff.rst_n)
        begin
            d.st  = DET_IDLE;
            d.tmr = '0;
        end
        else
        begin
            unique case (q.st)
                DET_IDLE:
                begin
                    if (!q.rst_prev)
                    begin
                        d.st  = DET_WAIT;
                        d.tmr = '0;
                    end
                end
                DET_WAIT:
                begin
                    if (q.tmr == TMR_END)
                    begin
                        d.found = q.load_s2;
                        d.st    = DET_DONE;
                    end
                    else
                    begin
                        d.tmr = q.tmr + TMR_W'(1);
                    end
                end
                DET_DONE:
                begin
                    d.st = DET_DONE;
                end
                default:
                begin
                    d.st = DET_IDLE;
                end
            endcase
        end

        // per-lane terminations; detection pulls outputs up weakly
        for (int ch = 0; ch < NCH; ch++)
        begin
            g = (ch < LANES) ? GRP_A : GRP_B;
            if (!q.eff.pd_n)
            begin
                d.in_term[ch]  = IN_HIZ;
                d.out_term[ch] = OUT_HIZ;
            end
            else if (!q.eff.rst_n)
            begin
                d.in_term[ch]  = IN_HIZ;
                d.out_term[ch] = OUT_PU2K;
            end
            else if (!q.eff.rxd[g] || (q.st == DET_DONE && q.found[ch]))
            begin
                d.in_term[ch]  = IN_PD50;
                d.out_term[ch] = q.sig_s2[ch] ? OUT_PU50 : OUT_PU2K;
            end
            else
            begin
                d.in_term[ch]  = IN_HIZ;
                d.out_term[ch] = OUT_PU2K;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '{regs: CFG_RST, eff: CFG_RST, st: DET_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_wr_refused   = q.refused;
    assign sig_present      = q.sig_s2;
    assign load_found       = q.found;
    assign load_found_grp_a = q.found[0];
    assign load_found_grp_b = q.found[LANES];
    assign detect_busy      = (q.st == DET_WAIT);
    assign in_term          = q.in_term;
    assign out_term         = q.out_term;
    assign loopback_n_out   = q.eff.lb_n;
    assign emph_deemph      = q.eff.emph;
    assign eq_code          = q.eff.eq;
    assign swing_code       = q.eff.sw;
    assign deemph_code      = q.eff.de;

    // ****************************************
    // checks
    // ****************************************
    always_comb
    begin
        for (int ch = 0; ch < NCH; ch++)
        begin
            drv_w[ch] = (q.out_term[ch] == OUT_PU50);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    write_lock_a:
        assert property (q.cap_done && q.pin_s2.mode && reg_wr
                         |=> $stable(q.regs) && q.refused)
        else $error("register changed in pin mode");

    write_take_a:
        assert property (q.cap_done && !q.pin_s2.mode && reg_wr
                         && reg_wr_idx == IDX_AEOC
                         |=> q.regs.eq[GRP_A] == $past(reg_wr_data[EQ_LSB +: EQ_W])
                             && !q.refused)
        else $error("equalizer write not taken");

    mode_live_a:
        assert property (q.pin_s2.mode |=> q.eff == $past(q.pin_s2.cfg))
        else $error("pin mode not following straps");

    strap_cap_a:
        assert property ($rose(q.cap_done) |-> q.regs == $past(q.pin_s2.cfg))
        else $error("straps not captured");

    power_off_a:
        assert property (!q.eff.pd_n |=> q.in_term == '0 && q.out_term == '0)
        else $error("lanes not high impedance in power down");

    det_hold_a:
        assert property (!q.eff.rst_n |=> q.st == DET_IDLE ##1 q.st == DET_IDLE
                         || q.eff.rst_n)
        else $error("detector not held in reset");

    det_start_a:
        assert property (q.st == DET_IDLE && q.eff.rst_n && !q.rst_prev
                         |=> q.st == DET_WAIT && q.tmr == '0)
        else $error("detection did not start on reset rise");

    det_sample_a:
        assert property (q.st == DET_WAIT && q.tmr == TMR_END && q.eff.rst_n
                         |=> q.st == DET_DONE && q.found == $past(q.load_s2))
        else $error("load not sampled at timeout");

    squelch_a:
        assert property (1'b1 |=> (drv_w & ~$past(q.sig_s2)) == '0)
        else $error("output driven without input signal");

    no_detect_a:
        assert property (q.eff.pd_n && q.eff.rst_n && !q.eff.rxd[GRP_A] && q.sig_s2[0]
                         |=> q.out_term[0] == OUT_PU50 && q.in_term[0] == IN_PD50)
        else $error("lane not driving with detection off");

    early_refuse_a:
        assert property (!q.cap_done && reg_wr |=> q.refused)
        else $error("write taken before strap capture");

    sig_follow_a:
        assert property (q.cap_done |-> sig_present == $past(input_level_valid, 2))
        else $error("signal present not tracking the input comparator");

    found_hold_a:
        assert property (q.st != DET_WAIT |=> $stable(load_found))
        else $error("receiver result changed outside a detection");

    reset_lanes_a:
        assert property (q.eff.pd_n && !q.eff.rst_n
                         |=> in_term == {NCH{IN_HIZ}} && out_term == {NCH{OUT_PU2K}})
        else $error("lanes not parked while channel reset is low");

    no_receiver_a:
        assert property (q.eff.pd_n && q.eff.rst_n && q.eff.rxd[GRP_B] && !q.found[LANES]
                         |=> in_term[LANES] == IN_HIZ && out_term[LANES] == OUT_PU2K)
        else $error("lane enabled without a receiver");

    receiver_idle_a:
        assert property (q.eff.pd_n && q.eff.rst_n && q.eff.rxd[GRP_B] && q.st == DET_DONE
                         && q.found[LANES] && !q.sig_s2[LANES]
                         |=> in_term[LANES] == IN_PD50 && out_term[LANES] == OUT_PU2K)
        else $error("found lane without signal not parked");

    receiver_drive_a:
        assert property (q.eff.pd_n && q.eff.rst_n && q.eff.rxd[GRP_B] && q.st == DET_DONE
                         && q.found[LANES] && q.sig_s2[LANES]
                         |=> in_term[LANES] == IN_PD50 && out_term[LANES] == OUT_PU50)
        else $error("found lane with signal not driving");

    bypass_idle_a:
        assert property (q.eff.pd_n && q.eff.rst_n && !q.eff.rxd[GRP_A] && !q.sig_s2[0]
                         |=> in_term[0] == IN_PD50 && out_term[0] == OUT_PU2K)
        else $error("idle lane not pulled up with detection off");

    detect_pullup_a:
        assert property (detect_busy && q.eff.pd_n && q.eff.rxd[GRP_B]
                         |=> out_term[LANES] == OUT_PU2K)
        else $error("no weak pull-up while sensing the load");

endmodule : rdcfg_core

// File: verif/rdcfg_far_end.sv
// far-side model: receiver load and incoming signal level on each lane
`timescale 1ns/100ps
module rdcfg_far_end
    import rdcfg_pkg::*;
(
    // clock
    input  wire logic                 mclk,
    // scenario set-up from the bench
    input  wire logic [NCH-1:0]       rx_present,
    input  wire logic [NCH-1:0]       sig_on,
    // lane side of the block
    input  wire logic [NCH-1:0][1:0]  out_term,
    output logic      [NCH-1:0]       load_sense,
    output logic      [NCH-1:0]       input_level_valid
);
    logic [NCH-1:0] junk_q = 8'h55;

    // sense level only means something under the weak pull-up, else it wanders
    always @(posedge mclk)
        junk_q <= ~junk_q;

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            load_sense[i] = (out_term[i] == OUT_PU2K) ? rx_present[i] : junk_q[i];
    end

    assign input_level_valid = sig_on;
endmodule : rdcfg_far_end

// File: verif/rdcfg_core_tb.sv
// self-checking bench for the configuration and lane control block
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rdcfg_core_tb
    import rdcfg_pkg::*;
;
    logic                      mclk = 1'b0;
    logic                      nrst, cfg_from_pins, loopback_n, chan_reset_n, power_down_n;
    logic                      rx_detect_en_a, rx_detect_en_b;
    logic                      emphasis_type_grp_a, emphasis_type_grp_b;
    logic [EQ_W-1:0]           equalizer_select_a, equalizer_select_b;
    logic [SW_W-1:0]           swing_select_a, swing_select_b;
    logic [DE_W-1:0]           deemph_level_select_a, deemph_level_select_b;
    logic                      reg_wr, reg_wr_refused, detect_busy, chk_req;
    logic [3:0]                reg_wr_idx;
    logic [7:0]                reg_wr_data;
    logic [NCH-1:0]            input_level_valid, load_sense, sig_present, load_found;
    logic [NCH-1:0]            rx_present, sig_on;
    logic                      load_found_grp_a, load_found_grp_b, loopback_n_out;
    logic [NCH-1:0][1:0]       in_term, out_term;
    logic [NGRP-1:0]           emph_deemph, m_rxd;
    logic [NGRP-1:0][EQ_W-1:0] eq_code;
    logic [NGRP-1:0][SW_W-1:0] swing_code;
    logic [NGRP-1:0][DE_W-1:0] deemph_code;
    logic [18:0]               reg_word;
    logic                      m_rst, m_pd, m_done;
    logic [33:0]               nt;
    logic [33:0]               notes[$];
    int                        failures = 0;
    int                        tests_run = 0;
    int                        r;

    always #5 mclk = ~mclk;

    rdcfg_core uut (
        .mclk(mclk), .nrst(nrst), .cfg_from_pins(cfg_from_pins), .loopback_n(loopback_n),
        .chan_reset_n(chan_reset_n), .power_down_n(power_down_n),
        .rx_detect_en_a(rx_detect_en_a), .rx_detect_en_b(rx_detect_en_b),
        .emphasis_type_grp_a(emphasis_type_grp_a), .emphasis_type_grp_b(emphasis_type_grp_b),
        .equalizer_select_a(equalizer_select_a), .equalizer_select_b(equalizer_select_b),
        .swing_select_a(swing_select_a), .swing_select_b(swing_select_b),
        .deemph_level_select_a(deemph_level_select_a),
        .deemph_level_select_b(deemph_level_select_b),
        .reg_wr(reg_wr), .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
        .reg_wr_refused(reg_wr_refused), .input_level_valid(input_level_valid),
        .load_sense(load_sense), .sig_present(sig_present), .load_found(load_found),
        .load_found_grp_a(load_found_grp_a), .load_found_grp_b(load_found_grp_b),
        .detect_busy(detect_busy), .in_term(in_term), .out_term(out_term),
        .loopback_n_out(loopback_n_out), .emph_deemph(emph_deemph), .eq_code(eq_code),
        .swing_code(swing_code), .deemph_code(deemph_code));

    rdcfg_far_end far (.mclk(mclk), .rx_present(rx_present), .sig_on(sig_on),
        .out_term(out_term), .load_sense(load_sense), .input_level_valid(input_level_valid));

    // ****************************************
    // observation and expectation
    // ****************************************
    function automatic logic [31:0] obs(input logic [1:0] s);
        case (s)
            2'h0: obs = 32'({eq_code, swing_code, deemph_code, emph_deemph, loopback_n_out});
            2'h1: obs = {in_term, out_term};
            2'h2: obs = 32'({load_found, load_found_grp_a, load_found_grp_b, sig_present});
            default: obs = 32'(reg_wr_refused);
        endcase
    endfunction : obs

    function automatic logic [18:0] pin_word();
        pin_word = {equalizer_select_b, equalizer_select_a, swing_select_b, swing_select_a,
            deemph_level_select_b, deemph_level_select_a, emphasis_type_grp_b,
            emphasis_type_grp_a, loopback_n};
    endfunction : pin_word

    function automatic logic [31:0] texp();
        logic [NCH-1:0][1:0] ei, eo;
        for (int i = 0; i < NCH; i++)
        begin
            ei[i] = IN_HIZ;
            eo[i] = m_pd ? OUT_PU2K : OUT_HIZ;
            if (m_pd && m_rst && (!m_rxd[i/4] || (m_done && rx_present[i])))
            begin
                ei[i] = IN_PD50;
                eo[i] = sig_on[i] ? OUT_PU50 : OUT_PU2K;
            end
        end
        texp = {ei, eo};
    endfunction : texp

    // results are taken when a refusal pulses or when the driver asks
    always @(posedge mclk)
    begin
        if (reg_wr_refused === 1'b1 || chk_req)
        begin
            nt = (notes.size() > 0) ? notes.pop_front() : 34'h300000000;
            `CHK(obs(nt[33:32]), nt[31:0])
        end
    end

    // ****************************************
    // drivers
    // ****************************************
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    task automatic check(input logic [1:0] s, input logic [31:0] e);
        @(negedge mclk);
        notes.push_back({s, e});
        chk_req = 1'b1;
        @(negedge mclk);
        chk_req = 1'b0;
    endtask : check

    task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic ok);
        @(negedge mclk);
        if (!ok)
            notes.push_back({2'h3, 32'h1});
        else if (i == 4'h2)
            reg_word[2:0] = d[2:0];
        else if (i == 4'h8)
            {reg_word[15:13], reg_word[10:9], reg_word[5:3]} = {d[2:0], d[4:3], d[7:5]};
        else if (i == 4'h9)
            {reg_word[18:16], reg_word[12:11], reg_word[8:6]} = {d[2:0], d[4:3], d[7:5]};
        {reg_wr, reg_wr_idx, reg_wr_data} = {1'b1, i, d};
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic det_run();
        int n;
        n = 0;
        wr(4'h5, 8'h01, 1'b1);
        m_rst = 1'b1;
        while (detect_busy !== 1'b1 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (detect_busy === 1'b1 && n < 1100)
        begin
            @(negedge mclk);
            n++;
        end
        `CHK(n, DET_CYC)
        m_done = 1'b1;
        idle(3);
        check(2'h2, 32'({rx_present, rx_present[0], rx_present[4], sig_on}));
        check(2'h1, texp());
    endtask : det_run

    task automatic report_and_stop();
        $display("comparisons=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end

    initial
    begin
        r = $urandom(32'hE43E6D5F);
        {nrst, reg_wr, reg_wr_idx, reg_wr_data, cfg_from_pins, chk_req} = '0;
        {chan_reset_n, power_down_n, rx_detect_en_a, rx_detect_en_b} = 4'h7;
        {m_rst, m_pd, m_rxd, m_done} = 5'hE;
        {rx_present, sig_on} = 16'($urandom());
        // lane B0 has a receiver first and none later, so both outcomes occur
        rx_present[LANES] = 1'b1;
        reg_word = 19'($urandom());
        {equalizer_select_b, equalizer_select_a, swing_select_b, swing_select_a,
            deemph_level_select_b, deemph_level_select_a, emphasis_type_grp_b,
            emphasis_type_grp_a, loopback_n} = reg_word;
        idle(3);
        check(2'h0, 32'h7);
        nrst = 1'b1;
        wr(4'h8, 8'hFF, 1'b0);
        idle(8);
        check(2'h0, 32'(reg_word));
        check(2'h1, texp());
        cfg_from_pins = 1'b1;
        {equalizer_select_b, equalizer_select_a, swing_select_b, swing_select_a,
            deemph_level_select_b, deemph_level_select_a} = 16'($urandom());
        idle(6);
        check(2'h0, 32'(pin_word()));
        wr(4'h9, 8'($urandom()), 1'b0);
        idle(4);
        cfg_from_pins = 1'b0;
        idle(6);
        check(2'h0, 32'(reg_word));
        for (int k = 0; k < 8; k++)
        begin
            wr(4'h8, {k[2:0], k[1:0], k[2:0]}, 1'b1);
            wr(4'h9, 8'($urandom()), 1'b1);
            wr(4'h2, {5'h0, k[2:0]}, 1'b1);
            wr(4'hB, 8'($urandom()), 1'b1);
            idle(3);
            check(2'h0, 32'(reg_word));
        end
        wr(4'h7, 8'h03, 1'b1);
        det_run();
        wr(4'h7, 8'h02, 1'b1);
        m_rxd = 2'h2;
        for (int k = 0; k < 3; k++)
        begin
            // lanes A0 and B0 see signal only on the middle pass
            sig_on = (8'($urandom()) & 8'hEE) | {3'h0, k[0], 3'h0, k[0]};
            idle(6);
            check(2'h2, 32'({rx_present, rx_present[0], rx_present[4], sig_on}));
            check(2'h1, texp());
        end
        wr(4'h5, 8'h00, 1'b1);
        wr(4'h7, 8'h03, 1'b1);
        {m_rst, m_done, m_rxd} = 4'h3;
        rx_present = ~rx_present;
        idle(4);
        check(2'h1, texp());
        det_run();
        wr(4'h6, 8'h00, 1'b1);
        m_pd = 1'b0;
        idle(4);
        check(2'h1, texp());
        idle(4);
        `CHK(notes.size(), 0)
        report_and_stop();
    end
endmodule : rdcfg_core_tb
